/* amc_top.sv */
/*
  Converter control core: multiplexer pairing and channel choice, gain
  code, start-of-conversion sources, track-and-hold timing, successive
  approximation sequencing, busy and completion flag, result alignment.
  Assumes a core-side register bus on the system clock, timer overflow
  pulses on the same clock, and an analog comparator and start pin that
  are asynchronous and therefore synchronised here.
*/
`timescale 1ns/1ps
module amc_top (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic [7:0]  i_sfr_wdata,
  input  wire logic        i_sfr_rd,
  output logic      [7:0]  o_sfr_rdata,
  input  wire logic        i_timer2_ovf,
  input  wire logic        i_timer3_ovf,
  input  wire logic        i_ext_convert_start,
  input  wire logic        i_standby,
  input  wire logic        i_irq_enable,
  input  wire logic        i_comp_above,
  output logic             o_analog_enable,
  output logic             o_track,
  output logic      [3:0]  o_mux_channel,
  output logic             o_mux_differential,
  output logic      [2:0]  o_gain_log2,
  output logic      [11:0] o_dac_code,
  output logic             o_conversion_busy,
  output logic             o_irq_request
);

  typedef enum {ST_IDLE, ST_TRACK, ST_CONVERT} amc_state_t;

  amc_sar_if sar ();

  amc_sar_clock_div u_div (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .sar     (sar)
  );

  // register file
  logic [3:0]  pair_cfg_reg;
  logic [3:0]  chan_sel_reg;
  logic [2:0]  div_code_reg;
  logic [2:0]  gain_code_reg;
  logic        enable_reg;
  logic        track_mode_reg;
  logic        done_flag_reg;
  logic        window_reg;
  logic [1:0]  mode_reg;
  logic        left_reg;
  logic [7:0]  result_hi_reg;
  logic [7:0]  result_lo_reg;

  // sequencing state
  amc_state_t  state_reg;
  logic [1:0]  track_cnt_reg;
  logic [11:0] code_reg;
  logic [11:0] mask_reg;
  logic        conv_diff_reg;
  logic [11:0] rate_cnt_reg;

  // synchronisers
  logic        pin_s1_reg;
  logic        pin_s2_reg;
  logic        pin_s3_reg;
  logic        comp_s1_reg;
  logic        comp_s2_reg;

  // decoded strobes and helpers
  logic        wr_control;
  logic        sw_start;
  logic        pin_rise;
  logic        trigger;
  logic        active;
  logic        sel_diff;
  logic        sel_pair_bit;
  logic        conv_end;
  logic [11:0] kept_code;
  logic [11:0] word;
  logic        track_now;
  logic [2:0]  gain_log;
  logic [7:0]  rd_value;

  ////////////////////////////////////////////////////////////////////////
  // asynchronous inputs pass two flops; the third stage of the start
  // pin exists only for its edge detector
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      pin_s1_reg  <= 1'b0;
      pin_s2_reg  <= 1'b0;
      pin_s3_reg  <= 1'b0;
      comp_s1_reg <= 1'b0;
      comp_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg  <= i_ext_convert_start;
      pin_s2_reg  <= pin_s1_reg;
      pin_s3_reg  <= pin_s2_reg;
      comp_s1_reg <= i_comp_above;
      comp_s2_reg <= comp_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger selection; all sources share one acceptance gate
  assign wr_control = i_sfr_wr && (i_sfr_addr == amc_pkg::ADDR_CONTROL);
  // a write of 1 to busy starts only when the written mode is software
  assign sw_start   = wr_control && i_sfr_wdata[amc_pkg::CTL_BUSY] &&
                      (i_sfr_wdata[amc_pkg::CTL_MODE_HI:amc_pkg::CTL_MODE_LO]
                       == amc_pkg::MODE_SOFT);
  assign pin_rise   = pin_s2_reg && !pin_s3_reg;
  assign active     = enable_reg && !i_standby;

  always_comb begin
    unique case (mode_reg)
      amc_pkg::MODE_SOFT:   trigger = sw_start;
      amc_pkg::MODE_TIMER3: trigger = i_timer3_ovf;
      amc_pkg::MODE_PIN:    trigger = pin_rise;
      amc_pkg::MODE_TIMER2: trigger = i_timer2_ovf;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // channel decode: a set top bit means the temperature sensor; the
  // pair bit is indexed by the channel's pair number
  assign sel_pair_bit = pair_cfg_reg[chan_sel_reg[2:1]];
  // odd member of a differential pair is reserved: it converts as the
  // pair would, so its result carries no meaning
  assign sel_diff = !chan_sel_reg[amc_pkg::CHAN_TEMP] &&
                    sel_pair_bit;

  ////////////////////////////////////////////////////////////////////////
  // approximation step: drop the trial bit when the comparator says the
  // input lies below the trial level, then try the next bit down.
  // the comparator is two cycles stale and the DAC code output one more, so the analog side must settle
  // within the conversion period less three system clocks
  assign kept_code = comp_s2_reg ? code_reg : (code_reg & ~mask_reg);
  assign conv_end  = (state_reg == ST_CONVERT) && sar.tick && mask_reg[0];
  // differential results leave the array in offset binary
  assign word = conv_diff_reg ? (kept_code ^ 12'h0800) : kept_code;

  ////////////////////////////////////////////////////////////////////////
  // rate limiter: a new start is refused until the minimum conversion
  // period has run out since the last accepted start
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      rate_cnt_reg <= 12'h000;
    end else if (state_reg == ST_IDLE && trigger && active &&
                 rate_cnt_reg == 12'h000) begin
      rate_cnt_reg <= 12'(amc_pkg::MIN_CONV_CYC - 1);
    end else if (rate_cnt_reg != 12'h000) begin
      rate_cnt_reg <= rate_cnt_reg - 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencer; dropping enable or entering standby aborts
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_reg     <= ST_IDLE;
      track_cnt_reg <= 2'h0;
      code_reg      <= 12'h000;
      mask_reg      <= 12'h000;
      conv_diff_reg <= 1'b0;
    end else if (!active) begin
      state_reg     <= ST_IDLE;
      mask_reg      <= 12'h000;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (trigger && rate_cnt_reg == 12'h000) begin
            conv_diff_reg <= sel_diff;
            track_cnt_reg <= 2'h0;
            if (track_mode_reg && mode_reg != amc_pkg::MODE_PIN) begin
              state_reg <= ST_TRACK;
            end else begin
              state_reg <= ST_CONVERT;
              code_reg  <= 12'h800;
              mask_reg  <= 12'h800;
            end
          end
        end
        ST_TRACK: begin
          if (sar.tick) begin
            if (track_cnt_reg == 2'(amc_pkg::TRACK_SAR_CLKS - 1)) begin
              state_reg <= ST_CONVERT;
              code_reg  <= 12'h800;
              mask_reg  <= 12'h800;
            end else begin
              track_cnt_reg <= track_cnt_reg + 2'h1;
            end
          end
        end
        ST_CONVERT: begin
          if (sar.tick) begin
            code_reg <= kept_code | (mask_reg >> 1);
            mask_reg <= mask_reg >> 1;
            if (mask_reg[0]) begin
              state_reg <= ST_IDLE;
              code_reg  <= kept_code;
            end
          end
        end
      endcase
    end
  end

  assign sar.div_code = div_code_reg;
  assign sar.run      = (state_reg != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // configuration registers; unused upper bits are never stored
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      pair_cfg_reg  <= amc_pkg::PAIR_CFG_RST;
      chan_sel_reg  <= amc_pkg::CHAN_SEL_RST;
      div_code_reg  <= amc_pkg::CLK_GAIN_RST[amc_pkg::CFG_DIV_HI:
                                             amc_pkg::CFG_DIV_LO];
      gain_code_reg <= amc_pkg::CLK_GAIN_RST[amc_pkg::CFG_GAIN_HI:
                                             amc_pkg::CFG_GAIN_LO];
    end else if (i_sfr_wr) begin
      unique case (i_sfr_addr)
        amc_pkg::ADDR_PAIR_CFG:
          pair_cfg_reg <= i_sfr_wdata[amc_pkg::PAIR_BITS-1:0];
        amc_pkg::ADDR_CHAN_SEL:
          chan_sel_reg <= i_sfr_wdata[amc_pkg::CHAN_BITS-1:0];
        amc_pkg::ADDR_CLK_GAIN: begin
          div_code_reg  <= i_sfr_wdata[amc_pkg::CFG_DIV_HI:
                                       amc_pkg::CFG_DIV_LO];
          gain_code_reg <= i_sfr_wdata[amc_pkg::CFG_GAIN_HI:
                                       amc_pkg::CFG_GAIN_LO];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register; busy is hardware-owned, so only its start effect
  // reaches the logic
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      enable_reg     <= amc_pkg::CONTROL_RST[amc_pkg::CTL_ENABLE];
      track_mode_reg <= amc_pkg::CONTROL_RST[amc_pkg::CTL_TRACK];
      window_reg     <= amc_pkg::CONTROL_RST[amc_pkg::CTL_WINDOW];
      mode_reg       <= amc_pkg::CONTROL_RST[amc_pkg::CTL_MODE_HI:
                                             amc_pkg::CTL_MODE_LO];
      left_reg       <= amc_pkg::CONTROL_RST[amc_pkg::CTL_LEFT];
    end else if (wr_control) begin
      enable_reg     <= i_sfr_wdata[amc_pkg::CTL_ENABLE];
      track_mode_reg <= i_sfr_wdata[amc_pkg::CTL_TRACK];
      window_reg     <= i_sfr_wdata[amc_pkg::CTL_WINDOW];
      mode_reg       <= i_sfr_wdata[amc_pkg::CTL_MODE_HI:
                                    amc_pkg::CTL_MODE_LO];
      left_reg       <= i_sfr_wdata[amc_pkg::CTL_LEFT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // completion flag: the end of a conversion beats a software clear
  // landing in the same cycle, so no completion is ever lost
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      done_flag_reg <= amc_pkg::CONTROL_RST[amc_pkg::CTL_DONE];
    end else if (conv_end) begin
      done_flag_reg <= 1'b1;
    end else if (wr_control) begin
      done_flag_reg <= i_sfr_wdata[amc_pkg::CTL_DONE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result bytes are loaded once, at the end of a conversion, in the
  // alignment chosen at that moment
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      result_hi_reg <= amc_pkg::RESULT_RST;
      result_lo_reg <= amc_pkg::RESULT_RST;
    end else if (conv_end) begin
      if (left_reg) begin
        result_hi_reg <= word[11:4];
        result_lo_reg <= {word[3:0], 4'h0};
      end else begin
        result_hi_reg <= {{4{conv_diff_reg & word[11]}},
                          word[11:8]};
        result_lo_reg <= word[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; unused and unmapped bits read zero
  always_comb begin
    unique case (i_sfr_addr)
      amc_pkg::ADDR_PAIR_CFG: rd_value = {4'h0, pair_cfg_reg};
      amc_pkg::ADDR_CHAN_SEL: rd_value = {4'h0, chan_sel_reg};
      amc_pkg::ADDR_CLK_GAIN: rd_value = {div_code_reg, 2'b00,
                                          gain_code_reg};
      amc_pkg::ADDR_RESULT_HI: rd_value = result_hi_reg;
      amc_pkg::ADDR_RESULT_LO: rd_value = result_lo_reg;
      amc_pkg::ADDR_CONTROL: rd_value = {enable_reg, track_mode_reg,
                                         done_flag_reg,
                                         (state_reg != ST_IDLE),
                                         mode_reg, window_reg, left_reg};
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= rd_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gain decode to a signed power of two for the amplifier
  always_comb begin
    unique casez (gain_code_reg)
      3'b000:  gain_log = amc_pkg::GAIN_LOG_X1;
      3'b001:  gain_log = amc_pkg::GAIN_LOG_X2;
      3'b010:  gain_log = amc_pkg::GAIN_LOG_X4;
      3'b011:  gain_log = amc_pkg::GAIN_LOG_X8;
      3'b10?:  gain_log = amc_pkg::GAIN_LOG_X16;
      default: gain_log = amc_pkg::GAIN_LOG_HALF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // tracking: mode 0 tracks whenever idle; mode 1 tracks only in the
  // timed window, or in pin mode while the start pin sits low
  always_comb begin
    if (!active) begin
      track_now = 1'b0;
    end else if (state_reg == ST_TRACK) begin
      track_now = 1'b1;
    end else if (state_reg == ST_CONVERT) begin
      track_now = 1'b0;
    end else if (!track_mode_reg) begin
      track_now = 1'b1;
    end else begin
      track_now = (mode_reg == amc_pkg::MODE_PIN) && !pin_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analog-facing and status outputs, all registered
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_analog_enable    <= 1'b0;
      o_track            <= 1'b0;
      o_mux_channel      <= 4'h0;
      o_mux_differential <= 1'b0;
      o_gain_log2        <= amc_pkg::GAIN_LOG_X1;
      o_dac_code         <= 12'h000;
      o_conversion_busy  <= 1'b0;
      o_irq_request      <= 1'b0;
    end else begin
      o_analog_enable    <= active;
      o_track            <= track_now;
      o_mux_channel      <= chan_sel_reg;
      // the odd member of a live pair never drives the pair positive
      o_mux_differential <= sel_diff && !chan_sel_reg[0];
      o_gain_log2        <= gain_log;
      o_dac_code         <= code_reg;
      o_conversion_busy  <= (state_reg != ST_IDLE);
      o_irq_request      <= done_flag_reg && i_irq_enable;
    end
  end

endmodule : amc_top

/* amc_pkg.sv */
/*
  Shared constants for the converter mux, gain and conversion control
  block: register addresses, field positions, reset values, start-mode
  codes and timing figures.
  Assumes a single 250 MHz system clock and an 8-bit special-function
  register bus driven by the core.
*/
package amc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [7:0] ADDR_PAIR_CFG   = 8'hBA;
  localparam logic [7:0] ADDR_CHAN_SEL   = 8'hBB;
  localparam logic [7:0] ADDR_CLK_GAIN   = 8'hBC;
  localparam logic [7:0] ADDR_RESULT_LO  = 8'hBE;
  localparam logic [7:0] ADDR_RESULT_HI  = 8'hBF;
  localparam logic [7:0] ADDR_CONTROL    = 8'hE8;

  // reset values
  localparam logic [3:0] PAIR_CFG_RST    = 4'h0;
  localparam logic [3:0] CHAN_SEL_RST    = 4'h0;
  localparam logic [7:0] CLK_GAIN_RST    = 8'h60;
  localparam logic [7:0] CONTROL_RST     = 8'h00;
  localparam logic [7:0] RESULT_RST      = 8'h00;

  // control register fields
  localparam int CTL_ENABLE   = 7;
  localparam int CTL_TRACK    = 6;
  localparam int CTL_DONE     = 5;
  localparam int CTL_BUSY     = 4;
  localparam int CTL_MODE_HI  = 3;
  localparam int CTL_MODE_LO  = 2;
  localparam int CTL_WINDOW   = 1;
  localparam int CTL_LEFT     = 0;

  // clock/gain register fields
  localparam int CFG_DIV_HI   = 7;
  localparam int CFG_DIV_LO   = 5;
  localparam int CFG_GAIN_HI  = 2;
  localparam int CFG_GAIN_LO  = 0;

  // channel and pair fields
  localparam int CHAN_BITS    = 4;
  localparam int CHAN_TEMP    = 3;
  localparam int PAIR_BITS    = 4;

  // start-of-conversion modes
  typedef enum logic [1:0] {
    MODE_SOFT   = 2'b00,
    MODE_TIMER3 = 2'b01,
    MODE_PIN    = 2'b10,
    MODE_TIMER2 = 2'b11
  } amc_mode_t;

  // gain as a signed power of two driven to the amplifier
  localparam logic [2:0] GAIN_LOG_X1    = 3'h0;
  localparam logic [2:0] GAIN_LOG_X2    = 3'h1;
  localparam logic [2:0] GAIN_LOG_X4    = 3'h2;
  localparam logic [2:0] GAIN_LOG_X8    = 3'h3;
  localparam logic [2:0] GAIN_LOG_X16   = 3'h4;
  localparam logic [2:0] GAIN_LOG_HALF  = 3'h7;

  // conversion timing
  localparam int RES_BITS        = 12;
  localparam int TRACK_SAR_CLKS  = 3;
  localparam int DIV_CODE_MAX    = 3;
  localparam int CLOCK_MHZ       = 250;
  localparam int MAX_RATE_KSPS   = 100;
  localparam int MIN_CONV_NS     = 1000000 / MAX_RATE_KSPS;
  localparam int MIN_CONV_CYC    =
    (MIN_CONV_NS * CLOCK_MHZ + 999) / 1000;

endpackage : amc_pkg

/* amc_sar_if.sv */
/*
  Carrier between the control core and its conversion-clock divider.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface amc_sar_if;
  logic [2:0] div_code;  // divider field from the configuration
  logic       run;       // divider counts only while a conversion runs
  logic       tick;      // one-cycle pulse per conversion-clock period

  modport ctrl (output div_code, output run, input tick);
  modport div  (input div_code, input run, output tick);
endinterface : amc_sar_if

/* amc_sar_clock_div.sv */
/*
  Conversion-clock divider: turns the system clock into one tick pulse
  every 2, 4, 8 or 16 cycles.
  Assumes the control core raises run for the whole of a conversion.
*/
`timescale 1ns/1ps
module amc_sar_clock_div (
  input  wire logic i_clock,
  input  wire logic i_rstn,
  amc_sar_if.div    sar
);

  logic [3:0] count_reg;
  logic [3:0] limit;
  logic       tick_reg;

  ////////////////////////////////////////////////////////////////////////
  // ratio is 2 to the (code+1); codes above the last listed one stick
  // at the largest ratio so a stray code never speeds conversion up
  always_comb begin
    if (sar.div_code > 3'(amc_pkg::DIV_CODE_MAX)) begin
      limit = 4'hF;
    end else begin
      limit = 4'((5'h02 << sar.div_code) - 5'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // free count restarts at each conversion so the first period is whole
  always_ff @(posedge i_clock) begin
    if (!i_rstn || !sar.run) begin
      count_reg <= 4'h0;
      tick_reg  <= 1'b0;
    end else if (count_reg >= limit) begin
      count_reg <= 4'h0;
      tick_reg  <= 1'b1;
    end else begin
      count_reg <= count_reg + 4'h1;
      tick_reg  <= 1'b0;
    end
  end

  assign sar.tick = tick_reg;

endmodule : amc_sar_clock_div

/* amc_assertions.sv */
/*
  Port checker for the converter control core.
  Assumes it is bound onto amc_top and shares its clock and reset.
*/
`timescale 1ns/1ps
module amc_checker (
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic        i_sfr_wr,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic        i_sfr_rd,
  input wire logic [7:0]  o_sfr_rdata,
  input wire logic        i_standby,
  input wire logic        i_irq_enable,
  input wire logic        o_analog_enable,
  input wire logic        o_track,
  input wire logic [3:0]  o_mux_channel,
  input wire logic [2:0]  o_gain_log2,
  input wire logic        o_conversion_busy,
  input wire logic        o_irq_request
);
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  logic [11:0] gap_reg;
  ////////////////////////////////////////////////////////////////////////
  // cycles since the last start; saturates so the first start is legal
  always_ff @(posedge i_clock) begin
    if (!i_rstn) gap_reg <= 12'hfff;
    else if ($rose(o_conversion_busy)) gap_reg <= 12'h001;
    else if (gap_reg != 12'hfff) gap_reg <= gap_reg + 12'h001;
  end
  // gain codes 4 and 5 share one setting, as do 6 and 7
  function automatic logic [2:0] gmap(input logic [7:0] c);
    return c[2] ? (c[1] ? 3'h7 : 3'h4) : c[2:0];
  endfunction : gmap
  sequence busy_hold;
    o_conversion_busy [*8];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  gain_follow_a: assert property (
    i_sfr_wr && i_sfr_addr == amc_pkg::ADDR_CLK_GAIN
    |-> ##2 o_gain_log2 == gmap($past(i_sfr_wdata, 2)))
    else $error("gain output does not match code");
  chan_follow_a: assert property (
    i_sfr_wr && i_sfr_addr == amc_pkg::ADDR_CHAN_SEL
    |-> ##2 o_mux_channel == $past(i_sfr_wdata[3:0], 2))
    else $error("channel output does not follow write");
  unused_zero_a: assert property ((i_sfr_rd && (i_sfr_addr == 8'hba ||
    i_sfr_addr == 8'hbb)) |=> o_sfr_rdata[7:4] == 4'h0)
    else $error("unused bits read nonzero");
  standby_off_a: assert property (
    i_standby |=> !o_analog_enable && !o_track)
    else $error("analog still active in standby");
  irq_mask_a: assert property (!i_irq_enable |=> !o_irq_request)
    else $error("interrupt request while disabled");
  done_irq_a: assert property ($fell(o_conversion_busy) &&
    o_analog_enable && $past(i_irq_enable) |-> o_irq_request)
    else $error("no interrupt request at completion");
  busy_span_a: assert property ($rose(o_conversion_busy) |->
    busy_hold ##[16:992] !o_conversion_busy)
    else $error("busy span out of range");
  rate_gap_a: assert property ($rose(o_conversion_busy) |->
    gap_reg >= amc_pkg::MIN_CONV_CYC)
    else $error("starts closer than minimum spacing");
endmodule : amc_checker
bind amc_top amc_checker u_chk (.i_clock, .i_rstn, .i_sfr_addr,
  .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd, .o_sfr_rdata, .i_standby,
  .i_irq_enable, .o_analog_enable, .o_track, .o_mux_channel,
  .o_gain_log2, .o_conversion_busy, .o_irq_request);

/* amc_partner.sv */
/*
  Analog side model: channel levels and the trial comparator.
  Assumes the design samples the comparator through its own flops.
*/
`timescale 1ns/1ps
module amc_partner (
  input  wire logic        i_clock,
  input  wire logic        i_analog_enable,
  input  wire logic [3:0]  i_mux_channel,
  input  wire logic [11:0] i_dac_code,
  output logic             o_comp_above
);
  logic toggle_reg = 1'b0;
  // a powered-down comparator gives no stable level
  always @(posedge i_clock) toggle_reg <= ~toggle_reg;
  // each channel sits at code {channel, 0x5c}
  assign o_comp_above = i_analog_enable ?
    ({i_mux_channel, 8'h5c} >= i_dac_code) : toggle_reg;
endmodule : amc_partner

/* tb_adc_mux_gain_conversion_control.sv */
/*
  Register-level testbench for the converter control core.
  Assumes amc_top, amc_partner and the bound checker are compiled.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  $display("ERROR %s expected %h seen %h", n, e, g); err_count++; end end
module tb_adc_mux_gain_conversion_control;
  logic        i_clock = 0, i_rstn = 0, i_sfr_wr = 0, i_sfr_rd = 0;
  logic        i_timer2_ovf = 0, i_timer3_ovf = 0, i_standby = 0;
  logic        i_ext_convert_start = 0, i_irq_enable = 0, i_comp_above;
  logic [7:0]  i_sfr_addr = 0, i_sfr_wdata = 0, o_sfr_rdata;
  logic [3:0]  o_mux_channel;
  logic [2:0]  o_gain_log2;
  logic [11:0] o_dac_code;
  logic        o_analog_enable, o_track, o_mux_differential;
  logic        o_conversion_busy, o_irq_request;
  int          err_count = 0, checks_done = 0;
  logic [7:0]  ra [7] = '{8'hba, 8'hbb, 8'hbc, 8'he8, 8'hbe, 8'hbf, 8'hbd};
  logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [2:0]  gt [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h7, 3'h7};
  logic [7:0]  cm [4] = '{8'h80, 8'h84, 8'h88, 8'hcc};
  always #2 i_clock = ~i_clock;
  amc_top uut (.i_clock, .i_rstn, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata,
    .i_sfr_rd, .o_sfr_rdata, .i_timer2_ovf, .i_timer3_ovf,
    .i_ext_convert_start, .i_standby, .i_irq_enable, .i_comp_above,
    .o_analog_enable, .o_track, .o_mux_channel, .o_mux_differential,
    .o_gain_log2, .o_dac_code, .o_conversion_busy, .o_irq_request);
  amc_partner u_ana (.i_clock, .i_analog_enable(o_analog_enable),
    .i_mux_channel(o_mux_channel), .i_dac_code(o_dac_code),
    .o_comp_above(i_comp_above));
  ////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("mismatches %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // one-cycle strobes, launched just after an edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_clock);
    i_sfr_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    @(posedge i_clock);
    i_sfr_rd <= 1'b0;
    #1 `CHK("rdata", e, o_sfr_rdata)
  endtask : rd
  // waits out the rate window, fires the trigger of mode c[3:2]
  task conv(input logic [7:0] c, input logic [7:0] hi, input logic [7:0] lo);
    int n;
    wr(8'he8, c);
    repeat (2600) @(posedge i_clock);
    case (c[3:2])
      2'b00: wr(8'he8, c | 8'h10);
      2'b01: i_timer3_ovf <= 1'b1;
      2'b10: i_ext_convert_start <= 1'b1;
      default: i_timer2_ovf <= 1'b1;
    endcase
    @(posedge i_clock);
    i_timer3_ovf <= 1'b0;
    i_timer2_ovf <= 1'b0;
    n = 0;
    while (o_conversion_busy !== 1'b1 && n < 20) begin
      @(posedge i_clock);
      n++;
    end
    while (o_conversion_busy !== 1'b0 && n < 1000) begin
      @(posedge i_clock);
      n++;
    end
    i_ext_convert_start <= 1'b0;
    if (n >= 20 && n < 40 || n >= 1000) begin
      $display("ERROR busy span expected bounded seen %0d", n);
      err_count++;
      final_report();
    end
    rd(8'hbf, hi);
    rd(8'hbe, lo);
    rd(8'he8, c | 8'h20);
    `CHK("irq", 1'b1, o_irq_request)
  endtask : conv
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge i_clock);
    i_rstn <= 1'b1;
    wr(8'hbd, 8'hff);
    foreach (ra[i]) rd(ra[i], rv[i]);
    `CHK("gain", 3'h0, o_gain_log2)
    for (int g = 0; g < 8; g++) begin
      wr(8'hbc, 8'h78 | 8'(g));
      @(posedge i_clock);
      #1 `CHK("gain", gt[g], o_gain_log2)
      rd(8'hbc, 8'h60 | 8'(g));
    end
    wr(8'hbc, 8'h60);
    wr(8'hba, 8'hf1);
    rd(8'hba, 8'h01);
    wr(8'hbb, 8'hf2);
    rd(8'hbb, 8'h02);
    `CHK("chan", 4'h2, o_mux_channel)
    `CHK("diff", 1'b0, o_mux_differential)
    $display("test registers done");
    i_irq_enable <= 1'b1;
    // every start source; timer 2 also with the timed track window
    foreach (cm[i]) conv(cm[i], 8'h02, 8'h5c);
    `CHK("aen", 1'b1, o_analog_enable)
    `CHK("track", 1'b0, o_track)
    $display("test start modes done");
    wr(8'hbb, 8'h00);
    rd(8'hbb, 8'h00);
    `CHK("diff", 1'b1, o_mux_differential)
    wr(8'hbc, 8'h20);
    conv(8'h80, 8'hf8, 8'h5c);
    `CHK("track", 1'b1, o_track)
    wr(8'hbc, 8'he0);
    conv(8'h81, 8'h85, 8'hc0);
    // a start inside the rate window is dropped
    wr(8'he8, 8'h91);
    repeat (4) @(posedge i_clock);
    `CHK("busy", 1'b0, o_conversion_busy)
    $display("test differential done");
    repeat (2600) @(posedge i_clock);
    wr(8'he8, 8'h91);
    repeat (40) @(posedge i_clock);
    i_standby <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1 `CHK("aen", 1'b0, o_analog_enable)
    `CHK("busy", 1'b0, o_conversion_busy)
    @(posedge i_clock);
    i_standby <= 1'b0;
    rd(8'he8, 8'h81);
    rd(8'hbf, 8'h85);
    $display("test standby abort done");
    wr(8'he8, 8'hc8);
    rd(8'he8, 8'hc8);
    `CHK("track", 1'b1, o_track)
    @(posedge i_clock);
    i_ext_convert_start <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1 `CHK("track", 1'b0, o_track)
    $display("test pin track done");
    final_report();
  end
endmodule : tb_adc_mux_gain_conversion_control
